// ### palette_pkg.sv
// Purpose: Shared constants and carriers for the palette lookup table.
// Assumes: APB with 32-bit data; register offsets are word indices.
// Notes: Byte address of a register is four times its index.
package palette_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0] PALETTE_INDEX_IDX = 8'h15;
   localparam logic [7:0] PALETTE_DATA_IDX = 8'h17;
   localparam logic [7:0] DISPLAY_CTRL_IDX = 8'h18;
   localparam int ADDR_LSB = 2;

   // ==========================================================
   // Field layout
   localparam int COMP_LSB = 4;
   localparam int COMP_W = 4;
   localparam int DEPTH_LSB = 0;
   localparam int MONO_BIT = 2;
   localparam logic [7:0] INDEX_RESET = 8'h00;
   localparam logic [3:0] COMP_RESET = 4'h0;

   // ==========================================================
   // Pixels held by one display-buffer byte at each depth
   localparam logic [3:0] PIX_1BPP = 4'h8;
   localparam logic [3:0] PIX_2BPP = 4'h4;
   localparam logic [3:0] PIX_4BPP = 4'h2;
   localparam logic [3:0] PIX_8BPP = 4'h1;

   // ==========================================================
   // Colour depth codes
   typedef enum logic [1:0] {
      BPP1 = 2'h0,
      BPP2 = 2'h1,
      BPP4 = 2'h2,
      BPP8 = 2'h3
   } depth_e;

   // Component selector, one-hot.
   typedef enum logic [2:0] {
      SEL_RED = 3'h1,
      SEL_GREEN = 3'h2,
      SEL_BLUE = 3'h4
   } comp_sel_e;

   typedef struct packed {
      logic [3:0] red;
      logic [3:0] green;
      logic [3:0] blue;
   } rgb_s;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } pixel_byte_s;

endpackage

// ### palette_lookup_table.sv
// Purpose: Colour palette lookup table with APB access and pixel unpacking.
// Assumes: One clock; pixel bytes arrive one at a time from the fetch logic.
// Notes: Pixel output appears two cycles after a byte is accepted.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Table holds 256 entries of separate 4-bit red, green, blue.
// - Colour modes drive stored red, green, blue of the indexed entry.
// - Monochrome modes index the table but show green intensity only.
// - Colour depth bounds which table entries the pixels can reach.
// - Eight-bit index register at 15h selects the accessed entry.
// - Data register at 17h carries one component in its upper nibble.
// - After index write, accesses reach red, then green, then blue.
// - After third data access the index steps by one.
// - At 1 bpp, bit 0 shows entry 0, bit 1 entry 1.
// - At 2 bpp, codes 00 to 11 show entries 0 to 3.
// - At 4 bpp, nibble 0000 to 1111 selects entries 0 to 15.
// - A byte holds eight, four or two pixels at 1, 2, 4 bpp.
// - Leftmost pixel sits in the most significant bits of the byte.
// - At 8 bpp the whole byte is the table index.
// - Monochrome 8 bpp is unsupported; it falls back to 4 bpp.
module palette_lookup_table #(
   parameter int ENTRIES = 256,
   parameter int IDX_W = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire palette_pkg::pixel_byte_s pixelIn,
   output logic pixelReady,
   output palette_pkg::rgb_s pixelColour,
   output logic pixelValid
);

   // ==========================================================
   // Local sizes
   localparam int DEPTH_W = 2;
   localparam int CNT_W = 4;
   localparam int BYTE_W = 8;

   // ==========================================================
   // Storage and control state
   // storage array
   palette_pkg::rgb_s paletteTable_q [ENTRIES];
   logic [IDX_W-1:0] paletteIndex_q;
   palette_pkg::comp_sel_e compSel_q;
   palette_pkg::depth_e depth_q;
   logic mono_q;
   logic [31:0] readData_q;
   logic [BYTE_W-1:0] shiftByte_q;
   logic [CNT_W-1:0] pixLeft_q;
   logic [IDX_W-1:0] pixIdx_q;
   logic pixIdxValid_q;
   palette_pkg::rgb_s colour_q;
   logic colourValid_q;

   // ==========================================================
   // Decoded strobes and combinational values
   logic apbSetup;
   logic apbAccess;
   logic hitIndex;
   logic hitData;
   logic hitCtrl;
   logic hitAny;
   logic indexWrite;
   logic dataWrite;
   logic dataTouch;
   logic ctrlWrite;
   logic lastComp;
   logic [3:0] curComp;
   logic [3:0] wrComp;
   logic [31:0] readData;
   palette_pkg::depth_e effDepth;
   logic [CNT_W-1:0] loadCount;
   logic [IDX_W-1:0] nextPix;
   logic [BYTE_W-1:0] shiftedByte;
   logic loadByte;
   logic shiftStep;
   palette_pkg::rgb_s lookedUp;

   // ==========================================================
   // Helpers
   // One decoder serves every mapped register, so all of them share one aliasing policy.
   function automatic logic reg_hit(input logic [31:0] addr, input logic [7:0] idx);
      logic upperZero;
      logic lowerZero;
      upperZero = (addr[31:palette_pkg::ADDR_LSB+8] == '0);
      lowerZero = (addr[palette_pkg::ADDR_LSB-1:0] == '0);
      reg_hit = upperZero && lowerZero && (addr[palette_pkg::ADDR_LSB +: 8] == idx);
   endfunction

   function automatic logic [3:0] pick_comp(input palette_pkg::rgb_s e, input palette_pkg::comp_sel_e s);
      case (s)
         palette_pkg::SEL_RED: pick_comp = e.red;
         palette_pkg::SEL_GREEN: pick_comp = e.green;
         palette_pkg::SEL_BLUE: pick_comp = e.blue;
         default: pick_comp = e.red;
      endcase
   endfunction

   function automatic palette_pkg::comp_sel_e next_sel(input palette_pkg::comp_sel_e s);
      case (s)
         palette_pkg::SEL_RED: next_sel = palette_pkg::SEL_GREEN;
         palette_pkg::SEL_GREEN: next_sel = palette_pkg::SEL_BLUE;
         palette_pkg::SEL_BLUE: next_sel = palette_pkg::SEL_RED;
         default: next_sel = palette_pkg::SEL_RED;
      endcase
   endfunction

   function automatic palette_pkg::rgb_s put_comp(input palette_pkg::rgb_s e, input palette_pkg::comp_sel_e s,
                                                  input logic [3:0] v);
      put_comp = e;
      case (s)
         palette_pkg::SEL_RED: put_comp.red = v;
         palette_pkg::SEL_GREEN: put_comp.green = v;
         palette_pkg::SEL_BLUE: put_comp.blue = v;
         default: put_comp.red = v;
      endcase
   endfunction

   function automatic palette_pkg::depth_e eff_depth(input palette_pkg::depth_e d, input logic m);
      eff_depth = d;
      if (m && d == palette_pkg::BPP8) begin
         eff_depth = palette_pkg::BPP4;
      end
   endfunction

   function automatic logic [CNT_W-1:0] pixels_per_byte(input palette_pkg::depth_e d);
      case (d)
         palette_pkg::BPP1: pixels_per_byte = palette_pkg::PIX_1BPP;
         palette_pkg::BPP2: pixels_per_byte = palette_pkg::PIX_2BPP;
         palette_pkg::BPP4: pixels_per_byte = palette_pkg::PIX_4BPP;
         default: pixels_per_byte = palette_pkg::PIX_8BPP;
      endcase
   endfunction

   function automatic logic [IDX_W-1:0] pixel_of(input palette_pkg::depth_e d, input logic [7:0] b);
      case (d)
         palette_pkg::BPP1: pixel_of = IDX_W'(b[7]);
         palette_pkg::BPP2: pixel_of = IDX_W'(b[7:6]);
         palette_pkg::BPP4: pixel_of = IDX_W'(b[7:4]);
         palette_pkg::BPP8: pixel_of = IDX_W'(b);
         default: pixel_of = '0;
      endcase
   endfunction

   function automatic logic [7:0] shift_out(input palette_pkg::depth_e d, input logic [7:0] b);
      case (d)
         palette_pkg::BPP1: shift_out = {b[6:0], 1'b0};
         palette_pkg::BPP2: shift_out = {b[5:0], 2'h0};
         default: shift_out = {b[3:0], 4'h0};
      endcase
   endfunction

   function automatic palette_pkg::rgb_s shade(input palette_pkg::rgb_s e, input logic m);
      shade = e;
      if (m) begin
         shade.red = e.green;
         shade.blue = e.green;
      end
   endfunction

   // ==========================================================
   // APB decode
   // A zero-wait slave keeps the component sequence simple: one access, one step.
   assign apbSetup = psel && !penable;
   assign apbAccess = psel && penable;
   assign hitIndex = reg_hit(paddr, palette_pkg::PALETTE_INDEX_IDX);
   assign hitData = reg_hit(paddr, palette_pkg::PALETTE_DATA_IDX);
   assign hitCtrl = reg_hit(paddr, palette_pkg::DISPLAY_CTRL_IDX);
   assign hitAny = hitIndex || hitData || hitCtrl;

   assign indexWrite = apbAccess && pwrite && hitIndex;
   assign dataWrite = apbAccess && pwrite && hitData;
   assign dataTouch = apbAccess && hitData;
   assign ctrlWrite = apbAccess && pwrite && hitCtrl;
   assign lastComp = (compSel_q == palette_pkg::SEL_BLUE);

   assign pready = 1'b1;
   assign pslverr = apbAccess && !hitAny;

   assign curComp = pick_comp(paletteTable_q[paletteIndex_q], compSel_q);
   assign wrComp = pwdata[palette_pkg::COMP_LSB +: palette_pkg::COMP_W];

   always_comb begin
      readData = 32'h0000_0000;
      if (hitIndex) begin
         readData[IDX_W-1:0] = paletteIndex_q;
      end else if (hitData) begin
         readData[palette_pkg::COMP_LSB +: palette_pkg::COMP_W] = curComp;
      end else if (hitCtrl) begin
         readData[palette_pkg::DEPTH_LSB +: DEPTH_W] = depth_q;
         readData[palette_pkg::MONO_BIT] = mono_q;
      end
   end

   // Read data is captured in the setup cycle and then stands through the access phase.
   // Capturing later would show the component after the selector has already moved on.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         readData_q <= 32'h0000_0000;
      end else if (apbSetup) begin
         readData_q <= readData;
      end
   end

   assign prdata = readData_q;

   // ==========================================================
   // Index and component selector
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         paletteIndex_q <= IDX_W'(palette_pkg::INDEX_RESET);
      end else if (indexWrite) begin
         paletteIndex_q <= pwdata[IDX_W-1:0];
      end else if (dataTouch && lastComp) begin
         paletteIndex_q <= paletteIndex_q + IDX_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         compSel_q <= palette_pkg::SEL_RED;
      end else if (indexWrite) begin
         compSel_q <= palette_pkg::SEL_RED;
      end else if (dataTouch) begin
         compSel_q <= next_sel(compSel_q);
      end
   end

   // Table contents are not reset; software loads the palette before display.
   always_ff @(posedge clk) begin
      if (dataWrite) begin
         paletteTable_q[paletteIndex_q] <= put_comp(paletteTable_q[paletteIndex_q], compSel_q, wrComp);
      end
   end

   // ==========================================================
   // Display control
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         depth_q <= palette_pkg::BPP1;
         mono_q <= 1'b0;
      end else if (ctrlWrite) begin
         depth_q <= palette_pkg::depth_e'(pwdata[palette_pkg::DEPTH_LSB +: DEPTH_W]);
         mono_q <= pwdata[palette_pkg::MONO_BIT];
      end
   end

   // ==========================================================
   // Pixel unpacking
   // mono fallback
   assign effDepth = eff_depth(depth_q, mono_q);
   assign loadCount = pixels_per_byte(effDepth);
   // Ready on the last pixel lets the next byte load without a gap in the stream.
   assign pixelReady = (pixLeft_q <= CNT_W'(1));
   assign loadByte = pixelIn.valid && pixelReady;
   assign shiftStep = (pixLeft_q != '0);
   assign nextPix = pixel_of(effDepth, shiftByte_q);
   assign shiftedByte = shift_out(effDepth, shiftByte_q);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pixLeft_q <= '0;
      end else if (loadByte) begin
         pixLeft_q <= loadCount;
      end else if (shiftStep) begin
         pixLeft_q <= pixLeft_q - CNT_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         shiftByte_q <= '0;
      end else if (loadByte) begin
         shiftByte_q <= pixelIn.data;
      end else if (shiftStep) begin
         shiftByte_q <= shiftedByte;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pixIdx_q <= '0;
      end else begin
         pixIdx_q <= nextPix;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pixIdxValid_q <= 1'b0;
      end else begin
         pixIdxValid_q <= shiftStep;
      end
   end

   // ==========================================================
   // Colour output
   // full colour
   assign lookedUp = paletteTable_q[pixIdx_q];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         colourValid_q <= 1'b0;
      end else begin
         colourValid_q <= pixIdxValid_q;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         colour_q <= '0;
      end else begin
         colour_q <= shade(lookedUp, mono_q);
      end
   end

   assign pixelColour = colour_q;
   assign pixelValid = colourValid_q;

endmodule

`default_nettype wire

// ### palette_lookup_table_monitor.sv
// Purpose: Port checker for the palette table.
// Assumes: Zero-wait APB slave.
// Notes: Pixel latency may be two or three cycles.
`timescale 1ns/1ps
`default_nettype none
module palette_lookup_table_monitor (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire palette_pkg::pixel_byte_s pixelIn,
   input wire logic pixelReady,
   input wire logic pixelValid
);
   // ======================
   // Checks
   logic acc, hit, take;
   assign acc = psel && penable;
   assign hit = paddr inside {32'h54, 32'h5C, 32'h60};
   assign take = pixelIn.valid && pixelReady;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_err_unmapped:
      assert property (acc && !hit |-> pslverr && prdata == 32'h0) else $error("unmapped access accepted");
   a_mapped_ok:
      assert property (acc && hit |-> !pslverr && pready) else $error("mapped access refused");
   a_data_nibble:
      assert property (acc && !pwrite && paddr == 32'h5C |-> prdata[3:0] == 4'h0) else $error("low nibble set");
   a_data_upper:
      assert property (acc && !pwrite && paddr == 32'h5C |-> prdata[31:8] == 24'h0) else $error("upper bits set");
   a_pixel_latency:
      assert property (take |-> ##[2:3] pixelValid) else $error("pixel late");
   a_pixel_cause:
      assert property (pixelValid |-> $past(pixelValid) || $past(take, 2) || $past(take, 3)) else $error("stray pixel");
   a_pixel_stream:
      assert property (pixelValid && !pixelReady |=> pixelValid) else $error("pixel gap");
   a_reset_idle:
      assert property ($fell(sys_rst) |-> pixelReady && !pixelValid) else $error("not idle after reset");
   cover property (take);
   cover property (acc && !hit);
   cover property (pixelValid && !pixelReady);
endmodule
bind palette_lookup_table palette_lookup_table_monitor mon_u (.clk(clk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pixelIn(pixelIn), .pixelReady(pixelReady), .pixelValid(pixelValid));
`default_nettype wire

// ### apb_host_model.sv
// Purpose: Host processor that reaches the palette over APB.
// Assumes: Slave may insert wait states.
// Notes: Write data flips while idle so stale values show up.
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
   input wire logic clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // ======================
   // Transfers
   logic busy = 1'b0;
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   // Toggling stops while a transfer owns the write data, so only one driver acts per edge.
   always @(posedge clk) begin
      if (!busy) pwdata <= ~pwdata;
   end
   task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r, output logic e);
      busy = 1'b1;
      @(posedge clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'h0;
      busy = 1'b0;
   endtask
endmodule
`default_nettype wire

// ### palette_lookup_table_test.sv
// Purpose: Self-checking bench for the palette table.
// Assumes: Host model drives APB; bench feeds pixel bytes.
// Notes: Only written entries are ever displayed.
`timescale 1ns/1ps
`default_nettype none
module palette_lookup_table_test;
   // ======================
   // Bench
   localparam logic [31:0] IA = 32'h54;
   localparam logic [31:0] DA = 32'h5C;
   logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, pixelReady, pixelValid;
   logic [31:0] paddr, pwdata, prdata;
   palette_pkg::pixel_byte_s pixelIn;
   palette_pkg::rgb_s pixelColour;
   palette_pkg::rgb_s seenQ[$];
   int num_errors = 0;
   int n_tests = 0;
   palette_lookup_table dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pixelIn(pixelIn),
      .pixelReady(pixelReady), .pixelColour(pixelColour), .pixelValid(pixelValid));
   apb_host_model host_u (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (pixelValid === 1'b1) seenQ.push_back(pixelColour);
   end
   task automatic print_verdict;
      if (num_errors == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic palette_pkg::rgb_s ent(input logic [7:0] e, input logic m);
      ent = '{e[3:0], ~e[3:0], e[3:0] + 4'h5};
      if (m) ent = '{ent.green, ent.green, ent.green};
   endfunction
   task automatic acc(input logic w, input logic [31:0] a, d, input logic e);
      logic [31:0] r;
      logic er;
      host_u.xfer(w, a, d, r, er);
      check({31'h0, er}, {31'h0, e});
      if (!w) check(r, d);
   endtask
   task automatic entry(input logic w, input logic [7:0] e);
      palette_pkg::rgb_s c;
      c = ent(e, 1'b0);
      acc(w, DA, {24'h0, c.red, 4'h0}, 1'b0);
      acc(w, DA, {24'h0, c.green, 4'h0}, 1'b0);
      acc(w, DA, {24'h0, c.blue, 4'h0}, 1'b0);
   endtask
   task automatic px(input logic [1:0] d, input logic m, input logic [7:0] b);
      int n;
      int w;
      n = 8 >> ((m && d == 2'h3) ? 2'h2 : d);
      w = 8 / n;
      acc(1'b1, 32'h60, {29'h0, m, d}, 1'b0);
      acc(1'b0, 32'h60, {29'h0, m, d}, 1'b0);
      seenQ.delete();
      pixelIn <= '{1'b1, b};
      do @(posedge clk); while (pixelReady !== 1'b1);
      pixelIn <= '{1'b0, ~b};
      repeat (12) @(posedge clk);
      check(seenQ.size(), n);
      for (int k = 0; k < n; k++) begin
         check(32'(seenQ[k]), 32'(ent(8'((b >> (8 - w * (k + 1))) & ((1 << w) - 1)), m)));
      end
   endtask
   initial begin
      sys_rst = 1'b1;
      pixelIn = '0;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      acc(1'b0, IA, 32'h0, 1'b0);
      for (int e = 0; e < 16; e++) entry(1'b1, 8'(e));
      acc(1'b0, IA, 32'h10, 1'b0);
      acc(1'b1, IA, 32'hFF, 1'b0);
      entry(1'b1, 8'hFF);
      acc(1'b0, IA, 32'h0, 1'b0);
      acc(1'b1, IA, 32'h3, 1'b0);
      acc(1'b0, DA, 32'h30, 1'b0);
      acc(1'b1, IA, 32'h3, 1'b0);
      entry(1'b0, 8'h3);
      acc(1'b0, IA, 32'h4, 1'b0);
      acc(1'b0, 32'h58, 32'h0, 1'b1);
      px(2'h0, 1'b0, 8'h80);
      px(2'h1, 1'b0, 8'hE4);
      px(2'h2, 1'b0, 8'hF0);
      px(2'h3, 1'b0, 8'hFF);
      px(2'h2, 1'b1, 8'h1E);
      px(2'h3, 1'b1, 8'h3C);
      print_verdict();
   end
   initial begin
      repeat (4000) @(posedge clk);
      num_errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
